// file: hdl/dma_channel_control_source.sv
// Contract
// RULE1: Channel acts on events only while the module enable bit is one.
// RULE2: Start triggers are taken only while the start-trigger enable is one.
// RULE3: Active bit reads one during a transaction; hardware sets and clears it.
// RULE4: Abort triggers are taken only while the abort-trigger enable is one.
// RULE5: Pending bit is one while the buffer holds undelivered read data.
// RULE6: Destination mode field selects hold, increment or decrement; code 11 reserved.
// RULE7: Destination stop bit clears start-trigger enable on destination counter reload.
// RULE8: Region field selects data space, program flash or data EEPROM.
// RULE9: Source mode field moves source pointer hold, up or down per transfer.
// RULE10: Source stop bit clears start-trigger enable on source counter reload.
// RULE11: Transit byte buffer is readable and shows the byte in flight.
// RULE12: Writable 22-bit source start address over three byte registers.
// RULE13: Read-only 22-bit source pointer, upper byte top two bits zero.
// RULE14: Unused bits 4-3 and 1 of control register 0 read zero.
// RULE15: Software may enable and allow start triggers by writing 0xC0.
// RULE16: An abort clears both the start and abort trigger enables.
// RULE17: Abort mid-transaction finishes any read, then clears active; resumable.
// RULE18: All channel registers return to default on reset or enable clear.
// RULE19: Overrun flag sets when a start arrives during an unfinished message.
// RULE20: Source pointer loads from start address on source reload and first start.
// RULE21: All fields, buffer and pointers are zero after reset.
`timescale 1ns/10ps
module dma_channel_control_source (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_clk_en,
    input  wire logic                      i_hsel,
    input  wire logic [31:0]               i_haddr,
    input  wire logic [1:0]                i_htrans,
    input  wire logic                      i_hwrite,
    input  wire logic [2:0]                i_hsize,
    input  wire logic [31:0]               i_hwdata,
    input  wire logic                      i_hready,
    output logic      [31:0]               o_hrdata,
    output logic                           o_hreadyout,
    output logic                           o_hresp,
    input  wire dma_chan_pkg::chan_evt_type i_evt,
    output dma_chan_pkg::chan_cfg_type      o_cfg
);

    typedef struct packed {
        dma_chan_pkg::bus_state_type bus;
        logic [7:0]  addr;
        logic        write;
        logic        hready;
        logic        hresp;
        logic [31:0] rdata;
        logic        en;
        logic        start_en;
        logic        active;
        logic        abort_en;
        logic        pending;
        logic        soft_stop;
        logic        need_load;
        logic        overrun;
        logic [1:0]  dst_mode;
        logic        dst_stop;
        logic [1:0]  region;
        logic [1:0]  src_mode;
        logic        src_stop;
        logic [7:0]  buffer;
        logic [21:0] source_start_address;
        logic [21:0] source_current_pointer;
    } state_type;

    localparam state_type STATE_RESET = '{
        bus:       dma_chan_pkg::BUS_IDLE,
        addr:      dma_chan_pkg::RESET_BYTE,
        write:     1'b0,
        hready:    1'b1,
        hresp:     1'b0,
        rdata:     32'h00000000,
        en:        1'b0,
        start_en:  1'b0,
        active:    1'b0,
        abort_en:  1'b0,
        pending:   1'b0,
        soft_stop: 1'b0,
        need_load: 1'b1,
        overrun:   1'b0,
        dst_mode:  dma_chan_pkg::MODE_HOLD,
        dst_stop:  1'b0,
        region:    dma_chan_pkg::REGION_DATA,
        src_mode:  dma_chan_pkg::MODE_HOLD,
        src_stop:  1'b0,
        buffer:    dma_chan_pkg::RESET_BYTE,
        source_start_address:       dma_chan_pkg::RESET_PTR,
        source_current_pointer:      dma_chan_pkg::RESET_PTR
    };

    state_type st_r;
    state_type st_nxt;
    logic [7:0] ctl0_rd;
    logic [7:0] ctl1_rd;
    logic [7:0] rd_byte;
    logic       wr_now;
    logic       take_start;
    logic       take_abort;
    logic       en_clear;

    always_comb begin
        ctl0_rd = 8'h00;
        ctl0_rd[dma_chan_pkg::CTL0_EN_BIT]     = st_r.en;
        ctl0_rd[dma_chan_pkg::CTL0_START_BIT]  = st_r.start_en;
        ctl0_rd[dma_chan_pkg::CTL0_ACTIVE_BIT] = st_r.active;
        ctl0_rd[dma_chan_pkg::CTL0_ABORT_BIT]  = st_r.abort_en;
        ctl0_rd[dma_chan_pkg::CTL0_PEND_BIT]   = st_r.pending; // [RULE5] [RULE14]
        ctl1_rd = {st_r.dst_mode, st_r.dst_stop, st_r.region, st_r.src_mode, st_r.src_stop};
        unique case (st_r.addr)
            dma_chan_pkg::OFF_CTL0:      rd_byte = ctl0_rd;
            dma_chan_pkg::OFF_CTL1:      rd_byte = ctl1_rd;
            dma_chan_pkg::OFF_BUF:       rd_byte = st_r.buffer; // [RULE11]
            dma_chan_pkg::OFF_SSA_LOW:   rd_byte = st_r.source_start_address[7:0];
            dma_chan_pkg::OFF_SSA_HIGH:  rd_byte = st_r.source_start_address[15:8];
            dma_chan_pkg::OFF_SSA_UPPER: rd_byte = {2'h0, st_r.source_start_address[21:16]};
            dma_chan_pkg::OFF_PTR_LOW:   rd_byte = st_r.source_current_pointer[7:0];
            dma_chan_pkg::OFF_PTR_HIGH:  rd_byte = st_r.source_current_pointer[15:8];
            dma_chan_pkg::OFF_PTR_UPPER: rd_byte = {2'h0, st_r.source_current_pointer[21:16]}; // [RULE13]
            dma_chan_pkg::OFF_STATUS:    rd_byte = {7'h00, st_r.overrun};
            default:                     rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        st_nxt     = st_r;
        wr_now     = (st_r.bus == dma_chan_pkg::BUS_DATA) && st_r.write;
        en_clear   = 1'b0;
        take_start = 1'b0;
        take_abort = 1'b0;

        // One wait state on every transfer keeps read data coming straight from a flop.
        unique case (st_r.bus)
            dma_chan_pkg::BUS_IDLE: begin
                if (i_hsel && i_htrans[1] && i_hready) begin
                    st_nxt.bus    = dma_chan_pkg::BUS_DATA;
                    st_nxt.addr   = i_haddr[7:0];
                    st_nxt.write  = i_hwrite;
                    st_nxt.hready = 1'b0;
                end
            end
            dma_chan_pkg::BUS_DATA: begin
                st_nxt.bus    = dma_chan_pkg::BUS_IDLE;
                st_nxt.hready = 1'b1;
                st_nxt.rdata  = st_r.write ? 32'h00000000 : {24'h000000, rd_byte};
            end
            default: begin
                st_nxt.bus    = dma_chan_pkg::BUS_IDLE;
                st_nxt.hready = 1'b1;
            end
        endcase

        if (wr_now) begin
            unique case (st_r.addr)
                dma_chan_pkg::OFF_CTL0: begin
                    st_nxt.en       = i_hwdata[dma_chan_pkg::CTL0_EN_BIT];
                    st_nxt.start_en = i_hwdata[dma_chan_pkg::CTL0_START_BIT]; // [RULE15]
                    st_nxt.active   = i_hwdata[dma_chan_pkg::CTL0_ACTIVE_BIT];
                    st_nxt.abort_en = i_hwdata[dma_chan_pkg::CTL0_ABORT_BIT];
                    if (i_hwdata[dma_chan_pkg::CTL0_ACTIVE_BIT]) begin
                        st_nxt.soft_stop = 1'b0; // [RULE17]
                    end
                    if (!st_r.en && i_hwdata[dma_chan_pkg::CTL0_EN_BIT]) begin
                        st_nxt.need_load = 1'b1; // [RULE20]
                    end
                    en_clear = !i_hwdata[dma_chan_pkg::CTL0_EN_BIT];
                end
                dma_chan_pkg::OFF_CTL1: begin
                    st_nxt.dst_mode = i_hwdata[dma_chan_pkg::CTL1_DEST_ADDR_MODE_LSB +: 2]; // [RULE6]
                    st_nxt.dst_stop = i_hwdata[dma_chan_pkg::CTL1_DEST_RELOAD_STOP_BIT];
                    st_nxt.region   = i_hwdata[dma_chan_pkg::CTL1_SMR_LSB +: 2]; // [RULE8]
                    st_nxt.src_mode = i_hwdata[dma_chan_pkg::CTL1_SOURCE_ADDR_MODE_LSB +: 2];
                    st_nxt.src_stop = i_hwdata[dma_chan_pkg::CTL1_SOURCE_RELOAD_STOP_BIT];
                end
                dma_chan_pkg::OFF_SSA_LOW:   st_nxt.source_start_address[7:0]   = i_hwdata[7:0]; // [RULE12]
                dma_chan_pkg::OFF_SSA_HIGH:  st_nxt.source_start_address[15:8]  = i_hwdata[7:0];
                dma_chan_pkg::OFF_SSA_UPPER: st_nxt.source_start_address[21:16] = i_hwdata[5:0];
                dma_chan_pkg::OFF_STATUS: begin
                    if (i_hwdata[dma_chan_pkg::STAT_OVR_BIT]) begin
                        st_nxt.overrun = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (st_r.en && !en_clear) begin // [RULE1]
            take_start = i_evt.start && st_r.start_en; // [RULE2]
            take_abort = i_evt.abort && st_r.abort_en; // [RULE4]
            if (i_evt.msg_done) begin
                st_nxt.active = 1'b0; // [RULE3]
            end
            if (take_start) begin
                if (st_r.active && !i_evt.msg_done) begin
                    st_nxt.overrun = 1'b1; // [RULE19]
                end else begin
                    st_nxt.active = 1'b1; // [RULE3]
                    if (st_r.need_load) begin
                        st_nxt.source_current_pointer      = st_r.source_start_address; // [RULE20]
                        st_nxt.need_load = 1'b0;
                    end
                end
            end
            if (i_evt.wr_done) begin
                st_nxt.pending = 1'b0;
            end
            if (i_evt.rd_done) begin
                st_nxt.buffer  = i_evt.rd_data; // [RULE11]
                st_nxt.pending = 1'b1; // [RULE5]
                unique case (st_r.src_mode)
                    dma_chan_pkg::MODE_INC: st_nxt.source_current_pointer = st_r.source_current_pointer + 22'h000001; // [RULE9]
                    dma_chan_pkg::MODE_DEC: st_nxt.source_current_pointer = st_r.source_current_pointer - 22'h000001; // [RULE9]
                    default:                st_nxt.source_current_pointer = st_r.source_current_pointer;
                endcase
                if (st_r.soft_stop) begin
                    st_nxt.active    = 1'b0; // [RULE17]
                    st_nxt.soft_stop = 1'b0;
                end
            end
            if (i_evt.src_reload) begin
                st_nxt.source_current_pointer      = st_r.source_start_address; // [RULE20]
                st_nxt.need_load = 1'b0;
                if (st_r.src_stop) begin
                    st_nxt.start_en = 1'b0; // [RULE10]
                end
            end
            if (i_evt.dst_reload && st_r.dst_stop) begin
                st_nxt.start_en = 1'b0; // [RULE7]
            end
            if (take_abort) begin
                st_nxt.start_en = 1'b0; // [RULE16]
                st_nxt.abort_en = 1'b0; // [RULE16]
                // A read under way is finished first so the buffer never holds half a byte.
                if (st_r.active && i_evt.rd_busy && !i_evt.rd_done) begin
                    st_nxt.soft_stop = 1'b1; // [RULE17]
                end else begin
                    st_nxt.active = 1'b0; // [RULE17]
                end
            end
        end

        if (en_clear) begin
            st_nxt           = STATE_RESET; // [RULE18]
            st_nxt.bus       = dma_chan_pkg::BUS_IDLE;
            st_nxt.hready    = 1'b1;
            st_nxt.rdata     = 32'h00000000;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= STATE_RESET; // [RULE21]
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign o_hrdata          = st_r.rdata;
    assign o_hreadyout       = st_r.hready;
    assign o_hresp           = st_r.hresp;
    assign o_cfg.enable      = st_r.en;
    assign o_cfg.active      = st_r.active;
    assign o_cfg.pending     = st_r.pending;
    assign o_cfg.src_region  = st_r.region;
    assign o_cfg.src_mode    = st_r.src_mode;
    assign o_cfg.dst_mode    = st_r.dst_mode;
    assign o_cfg.src_ptr     = st_r.source_current_pointer;
    assign o_cfg.overrun     = st_r.overrun;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence seq_abort_taken;
        i_clk_en && st_r.en && st_r.abort_en && i_evt.abort && !wr_now;
    endsequence

    sequence seq_start_while_busy;
        i_clk_en && st_r.en && st_r.start_en && i_evt.start && st_r.active
            && !i_evt.msg_done && !wr_now;
    endsequence

    AST_DISABLED_IDLE: assert property ( // [RULE1]
        (i_clk_en && !st_r.en && !wr_now && i_evt.start) |=> !st_r.active)
        else $error("Disabled channel started a transaction.");

    AST_START_GATED: assert property ( // [RULE2]
        (i_clk_en && st_r.en && !st_r.start_en && !st_r.active && i_evt.start
            && !i_evt.abort && !wr_now) |=> !st_r.active)
        else $error("Start trigger taken while start enable was low.");

    AST_ABORT_CLEARS: assert property ( // [RULE16]
        seq_abort_taken |=> (!st_r.start_en && !st_r.abort_en))
        else $error("Abort did not clear both trigger enables.");

    AST_SOFT_STOP: assert property ( // [RULE17]
        (seq_abort_taken ##0 (st_r.active && i_evt.rd_busy && !i_evt.rd_done))
            |=> (st_r.soft_stop && st_r.active))
        else $error("Abort during a read did not wait for the read.");

    AST_OVERRUN: assert property ( // [RULE19]
        seq_start_while_busy |=> st_r.overrun)
        else $error("Overrun flag not set on early start.");

    AST_PENDING: assert property ( // [RULE5]
        (i_clk_en && st_r.en && i_evt.rd_done && !wr_now)
            |=> (st_r.pending && st_r.buffer == $past(i_evt.rd_data)))
        else $error("Read data not captured as pending.");

    AST_RELOAD_STOP: assert property ( // [RULE10]
        (i_clk_en && st_r.en && st_r.src_stop && i_evt.src_reload && !wr_now)
            |=> (!st_r.start_en && st_r.source_current_pointer == $past(st_r.source_start_address)))
        else $error("Source reload did not stop and reload pointer.");

    AST_DST_STOP: assert property ( // [RULE7]
        (i_clk_en && st_r.en && st_r.dst_stop && i_evt.dst_reload && !wr_now)
            |=> !st_r.start_en)
        else $error("Destination reload did not clear start enable.");

    AST_EN_CLEAR: assert property ( // [RULE18]
        (i_clk_en && wr_now && st_r.addr == dma_chan_pkg::OFF_CTL0
            && !i_hwdata[dma_chan_pkg::CTL0_EN_BIT])
            |=> (st_r.source_current_pointer == dma_chan_pkg::RESET_PTR && !st_r.active && !st_r.overrun))
        else $error("Enable clear did not return registers to default.");

    AST_BUS_WAIT: assert property (
        (i_clk_en && st_r.bus == dma_chan_pkg::BUS_IDLE && i_hsel && i_htrans[1] && i_hready)
            |=> !o_hreadyout ##1 (o_hreadyout || !$past(i_clk_en)))
        else $error("Bus answer did not take exactly one wait state.");

endmodule

// file: hdl/dma_chan_pkg.sv
package dma_chan_pkg;

    localparam int unsigned PTR_W = 22;

    localparam logic [7:0] OFF_CTL0      = 8'h00;
    localparam logic [7:0] OFF_CTL1      = 8'h04;
    localparam logic [7:0] OFF_BUF       = 8'h08;
    localparam logic [7:0] OFF_SSA_LOW   = 8'h0C;
    localparam logic [7:0] OFF_SSA_HIGH  = 8'h10;
    localparam logic [7:0] OFF_SSA_UPPER = 8'h14;
    localparam logic [7:0] OFF_PTR_LOW   = 8'h18;
    localparam logic [7:0] OFF_PTR_HIGH  = 8'h1C;
    localparam logic [7:0] OFF_PTR_UPPER = 8'h20;
    localparam logic [7:0] OFF_STATUS    = 8'h24;

    localparam int unsigned CTL0_EN_BIT     = 7;
    localparam int unsigned CTL0_START_BIT  = 6;
    localparam int unsigned CTL0_ACTIVE_BIT = 5;
    localparam int unsigned CTL0_ABORT_BIT  = 2;
    localparam int unsigned CTL0_PEND_BIT   = 0;
    localparam int unsigned CTL1_DEST_ADDR_MODE_LSB  = 6;
    localparam int unsigned CTL1_DEST_RELOAD_STOP_BIT   = 5;
    localparam int unsigned CTL1_SMR_LSB    = 3;
    localparam int unsigned CTL1_SOURCE_ADDR_MODE_LSB  = 1;
    localparam int unsigned CTL1_SOURCE_RELOAD_STOP_BIT   = 0;
    localparam int unsigned STAT_OVR_BIT    = 0;

    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_INC  = 2'h1;
    localparam logic [1:0] MODE_DEC  = 2'h2;

    localparam logic [1:0] REGION_DATA  = 2'h0;
    localparam logic [1:0] REGION_FLASH = 2'h1;

    localparam logic [7:0]  RESET_BYTE = 8'h00;
    localparam logic [21:0] RESET_PTR  = 22'h000000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_DATA = 2'b10
    } bus_state_type;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       rd_busy;
        logic       rd_done;
        logic [7:0] rd_data;
        logic       wr_done;
        logic       src_reload;
        logic       dst_reload;
        logic       msg_done;
    } chan_evt_type;

    typedef struct packed {
        logic        enable;
        logic        active;
        logic        pending;
        logic [1:0]  src_region;
        logic [1:0]  src_mode;
        logic [1:0]  dst_mode;
        logic [21:0] src_ptr;
        logic        overrun;
    } chan_cfg_type;

endpackage

// file: tb/engine_model.sv
`timescale 1ns/10ps
module engine_model (
    input  wire logic                  i_core_clk,
    output dma_chan_pkg::chan_evt_type o_evt
);
    dma_chan_pkg::chan_evt_type evt_r = '0;

    assign o_evt = evt_r;

    // Called just after a rising edge; each pulse lasts one cycle and a quiet cycle follows it.
    // Outside a read the data lines show the inverse of the last byte and each pulse inverts them again, so a stale capture fails.
    task automatic pulse(input int unsigned kind);
        evt_r.start      <= (kind == 0);
        evt_r.abort      <= (kind == 1);
        evt_r.wr_done    <= (kind == 2);
        evt_r.src_reload <= (kind == 3);
        evt_r.dst_reload <= (kind == 4);
        evt_r.msg_done   <= (kind == 5);
        @(posedge i_core_clk);
        evt_r <= '{rd_busy: evt_r.rd_busy, rd_data: ~evt_r.rd_data, default: 1'h0};
        @(posedge i_core_clk);
    endtask

    // A source read may be stretched by the caller, and an abort may ride on its first cycle.
    task automatic start_read(input logic with_abort);
        evt_r.rd_busy <= 1'h1;
        evt_r.abort   <= with_abort;
        @(posedge i_core_clk);
        evt_r.abort   <= 1'h0;
    endtask

    task automatic finish_read(input logic [7:0] data);
        evt_r.rd_done <= 1'h1;
        evt_r.rd_data <= data;
        @(posedge i_core_clk);
        evt_r.rd_done <= 1'h0;
        evt_r.rd_busy <= 1'h0;
        evt_r.rd_data <= ~data;
    endtask
endmodule

// file: tb/dma_channel_control_source_tb.sv
`timescale 1ns/10ps
module dma_channel_control_source_tb;
    logic                       clk = 1'h0;
    logic                       clk_en = 1'h1;
    logic                       rst_n = 1'h0;
    logic                       hsel = 1'h0;
    logic                       hwrite = 1'h0;
    logic [1:0]                 htrans = 2'h0;
    logic [2:0]                 hsize = 3'h2;
    logic [31:0]                haddr = '0;
    logic [31:0]                hwdata = '0;
    logic [31:0]                hrdata;
    logic                       hreadyout;
    logic                       hresp;
    dma_chan_pkg::chan_evt_type evt;
    dma_chan_pkg::chan_cfg_type cfg;
    int                         mismatches = 0;
    int                         total_checks = 0;

    always #12.5 clk = ~clk;

    dma_channel_control_source dma_channel_control_source_inst (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_evt(evt), .o_cfg(cfg)
    );

    engine_model engine_model_inst (.i_core_clk(clk), .o_evt(evt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready is registered, so looking at it on the falling edge gives the value of the next rise.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(negedge clk); while (hreadyout !== 1'h1);
        @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(negedge clk); while (hreadyout !== 1'h1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'h1, a, {24'h0, d}, r);
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'h0, a, '0, r);
        check(r, {24'h0, e});
    endtask

    task automatic t_reset;
        check(cfg, '0);
        for (int i = 0; i < 11; i++) begin
            rc(8'(i * 4), 8'h00);
        end
    endtask

    task automatic t_regs;
        wr(dma_chan_pkg::OFF_CTL1, 8'hFF);
        rc(dma_chan_pkg::OFF_CTL1, 8'hFF);
        wr(dma_chan_pkg::OFF_SSA_UPPER, 8'hFF);
        rc(dma_chan_pkg::OFF_SSA_UPPER, 8'h3F);
        wr(dma_chan_pkg::OFF_SSA_HIGH, 8'hC3);
        rc(dma_chan_pkg::OFF_SSA_HIGH, 8'hC3);
        wr(dma_chan_pkg::OFF_BUF, 8'hFF);
        rc(dma_chan_pkg::OFF_BUF, 8'h00);
        wr(dma_chan_pkg::OFF_PTR_UPPER, 8'hFF);
        rc(dma_chan_pkg::OFF_PTR_UPPER, 8'h00);
        wr(dma_chan_pkg::OFF_CTL0, 8'hBF);
        rc(dma_chan_pkg::OFF_CTL0, 8'hA4);
        wr(dma_chan_pkg::OFF_CTL0, 8'h00);
        rc(dma_chan_pkg::OFF_CTL1, 8'h00);
        rc(dma_chan_pkg::OFF_SSA_HIGH, 8'h00);
    endtask

    task automatic t_modes;
        logic [21:0] p;
        for (int m = 0; m < 4; m++) begin
            p = (m == 1) ? 22'h010100 : (m == 2) ? 22'h0100FE : 22'h0100FF;
            wr(dma_chan_pkg::OFF_CTL1, {2'(m), 1'h0, 2'(m), 2'(m), 1'h0});
            wr(dma_chan_pkg::OFF_SSA_LOW, 8'hFF);
            wr(dma_chan_pkg::OFF_SSA_UPPER, 8'h01);
            wr(dma_chan_pkg::OFF_CTL0, 8'hC0);
            engine_model_inst.pulse(0);
            @(negedge clk);
            check(32'(cfg.src_ptr), 32'h0100FF);
            @(posedge clk);
            engine_model_inst.start_read(1'h0);
            repeat (m) @(posedge clk);
            engine_model_inst.finish_read(8'hA5 ^ 8'(m));
            rc(dma_chan_pkg::OFF_BUF, 8'hA5 ^ 8'(m));
            rc(dma_chan_pkg::OFF_CTL0, 8'hE1);
            rc(dma_chan_pkg::OFF_PTR_LOW, p[7:0]);
            rc(dma_chan_pkg::OFF_PTR_HIGH, p[15:8]);
            rc(dma_chan_pkg::OFF_PTR_UPPER, {2'h0, p[21:16]});
            check(32'({cfg.src_region, cfg.dst_mode, cfg.src_mode}), 32'(m * 21));
            engine_model_inst.pulse(2);
            engine_model_inst.pulse(5);
            rc(dma_chan_pkg::OFF_CTL0, 8'hC0);
            wr(dma_chan_pkg::OFF_CTL0, 8'h00);
            rc(dma_chan_pkg::OFF_PTR_LOW, 8'h00);
        end
    endtask

    task automatic t_gates;
        engine_model_inst.start_read(1'h0);
        engine_model_inst.finish_read(8'h5A);
        rc(dma_chan_pkg::OFF_BUF, 8'h00);
        wr(dma_chan_pkg::OFF_CTL0, 8'h80);
        engine_model_inst.pulse(0);
        rc(dma_chan_pkg::OFF_CTL0, 8'h80);
        wr(dma_chan_pkg::OFF_CTL0, 8'hC0);
        engine_model_inst.pulse(0);
        engine_model_inst.pulse(0);
        rc(dma_chan_pkg::OFF_STATUS, 8'h01);
        check(32'(cfg.overrun), 32'h1);
        wr(dma_chan_pkg::OFF_STATUS, 8'h01);
        engine_model_inst.pulse(5);
        engine_model_inst.pulse(0);
        rc(dma_chan_pkg::OFF_STATUS, 8'h00);
        rc(dma_chan_pkg::OFF_CTL0, 8'hE0);
        wr(dma_chan_pkg::OFF_CTL0, 8'h00);
    endtask

    // A reload clears the start enable only when the stop bit of the same counter is set.
    task automatic t_reloads;
        logic [7:0] c[3] = '{8'h01, 8'h20, 8'h20};
        int         k[3] = '{3, 4, 3};
        logic [7:0] e[3] = '{8'h80, 8'h80, 8'hC0};
        for (int i = 0; i < 3; i++) begin
            wr(dma_chan_pkg::OFF_CTL1, c[i]);
            wr(dma_chan_pkg::OFF_SSA_LOW, 8'h77);
            wr(dma_chan_pkg::OFF_CTL0, 8'hC0);
            engine_model_inst.pulse(k[i]);
            rc(dma_chan_pkg::OFF_CTL0, e[i]);
            rc(dma_chan_pkg::OFF_PTR_LOW, (k[i] == 3) ? 8'h77 : 8'h00);
            wr(dma_chan_pkg::OFF_CTL0, 8'h00);
        end
    endtask

    task automatic t_abort;
        wr(dma_chan_pkg::OFF_CTL0, 8'hC0);
        engine_model_inst.pulse(0);
        engine_model_inst.pulse(1);
        rc(dma_chan_pkg::OFF_CTL0, 8'hE0);
        wr(dma_chan_pkg::OFF_CTL0, 8'hE4);
        engine_model_inst.start_read(1'h1);
        rc(dma_chan_pkg::OFF_CTL0, 8'hA0);
        engine_model_inst.finish_read(8'h3C);
        rc(dma_chan_pkg::OFF_CTL0, 8'h81);
        rc(dma_chan_pkg::OFF_BUF, 8'h3C);
        wr(dma_chan_pkg::OFF_CTL0, 8'hA0);
        rc(dma_chan_pkg::OFF_CTL0, 8'hA1);
        engine_model_inst.pulse(2);
        wr(dma_chan_pkg::OFF_CTL0, 8'hE4);
        engine_model_inst.pulse(1);
        rc(dma_chan_pkg::OFF_CTL0, 8'h80);
        wr(dma_chan_pkg::OFF_CTL0, 8'h00);
    endtask

    // Clock enable low stretches a data phase and hides events; a mid-run reset clears all.
    task automatic t_freeze;
        wr(dma_chan_pkg::OFF_CTL0, 8'hC0);
        fork
            rc(dma_chan_pkg::OFF_CTL0, 8'hC0);
            begin
                @(posedge clk);
                clk_en <= 1'h0;
                repeat (3) @(posedge clk);
                clk_en <= 1'h1;
            end
        join
        clk_en <= 1'h0;
        engine_model_inst.pulse(0);
        clk_en <= 1'h1;
        rc(dma_chan_pkg::OFF_CTL0, 8'hC0);
        engine_model_inst.pulse(0);
        rc(dma_chan_pkg::OFF_CTL0, 8'hE0);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        check(32'(cfg), 32'h0);
        rc(dma_chan_pkg::OFF_CTL0, 8'h00);
    endtask

    task automatic test_done;
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        t_reset;
        t_regs;
        t_modes;
        t_gates;
        t_reloads;
        t_abort;
        t_freeze;
        test_done;
    end

    // The whole sequence needs well under 3000 cycles; this bound only catches a hang.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done;
    end
endmodule
